// >>> core/fotp_core.sv
`timescale 1ns/10ps
`default_nettype none
module fotp_core #(
  parameter int PART_BITS = 2,
  parameter logic [1:0] PARAM_PART = 2'h_0,
  parameter logic [63:0] UNIQUE_ID = 64'h_0123_4567_89ab_cdef // arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [PART_BITS-1:0] part_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic supply_low_i,
  input wire logic main_busy_i,
  input wire logic [PART_BITS-1:0] main_busy_part_i,
  input wire logic param_busy_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic conflict_o,
  output logic [7:0] status_flags_o,
  output logic [15:0] read_configuration_word_o,
  output logic read_mode_select_o,
  output logic [2:0] first_access_latency_o,
  output logic stall_polarity_o,
  output logic output_hold_length_o,
  output logic stall_timing_o,
  output logic burst_order_o,
  output logic clock_edge_select_o,
  output logic burst_wrap_disable_o,
  output logic [4:0] burst_words_o,
  output logic single_read_only_o
);

  // ==========================================
  // state
  typedef enum logic [4:0] {
    FOTP_ARRAY = 5'b0_0001,
    FOTP_ID = 5'b0_0010,
    FOTP_STATUS = 5'b0_0100,
    FOTP_CFG_WAIT = 5'b0_1000,
    FOTP_OTP_WAIT = 5'b1_0000
  } fotp_mode_e;

  fotp_mode_e mode;
  fotp_mode_e next_mode;
  logic [15:0] otp_user [fotp_pkg::OTP_WORDS/2];
  logic [15:0] otp_lock_bits;
  logic [15:0] read_configuration_word;
  logic [7:0] status_flags;
  logic [$clog2(fotp_pkg::PROG_CYCLES+1)-1:0] prog_cnt;
  logic prog_busy;
  logic [1:0] prog_idx;
  logic [15:0] prog_data;

  function automatic logic is_otp_addr(input logic [15:0] a);
    is_otp_addr = (a[7:0] >= fotp_pkg::ID_OTP_LOCK) && (a[7:0] <= fotp_pkg::ID_OTP_LAST);
  endfunction

  function automatic logic [4:0] burst_len(input logic [2:0] code);
    case (code)
      fotp_pkg::LEN_4: burst_len = fotp_pkg::BURST_4;
      fotp_pkg::LEN_8: burst_len = fotp_pkg::BURST_8;
      fotp_pkg::LEN_16: burst_len = fotp_pkg::BURST_16;
      default: burst_len = fotp_pkg::BURST_NONE;
    endcase
  endfunction

  logic wr_cmd;
  logic [7:0] cmd;
  logic otp_busy_any;
  logic otp_blocked;
  logic prog_start;
  assign cmd = data_i[7:0];
  assign prog_start = wr_i && mode == FOTP_OTP_WAIT && !supply_low_i && part_i == PARAM_PART
                      && addr_i[7:0] >= fotp_pkg::ID_OTP_USER_FIRST
                      && addr_i[7:0] <= fotp_pkg::ID_OTP_LAST
                      && otp_lock_bits[fotp_pkg::LOCK_USER_BIT];
  assign wr_cmd = wr_i && (mode != FOTP_CFG_WAIT) && (mode != FOTP_OTP_WAIT);
  assign otp_busy_any = prog_busy;
  assign otp_blocked = param_busy_i || (part_i == PARAM_PART && otp_busy_any);

  // ==========================================
  // command sequencer
  always_comb begin
    next_mode = mode;
    if (wr_i) begin
      case (mode)
        FOTP_CFG_WAIT: next_mode = FOTP_ARRAY;
        FOTP_OTP_WAIT: next_mode = FOTP_STATUS;
        default: begin
          case (cmd)
            fotp_pkg::CMD_READ_ARRAY: next_mode = FOTP_ARRAY;
            fotp_pkg::CMD_READ_ID: next_mode = FOTP_ID;
            fotp_pkg::CMD_READ_STATUS: next_mode = FOTP_STATUS;
            fotp_pkg::CMD_CFG_SETUP: next_mode = FOTP_CFG_WAIT;
            fotp_pkg::CMD_OTP_PROGRAM: next_mode = FOTP_OTP_WAIT;
            default: next_mode = mode;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode <= FOTP_ARRAY;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================
  // read configuration word
  // second cycle repeats the value, so only the confirm copy is kept
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      read_configuration_word <= fotp_pkg::CFG_RESET;
    end else if (wr_i && mode == FOTP_CFG_WAIT && cmd == fotp_pkg::CMD_CFG_CONFIRM) begin
      // no supply check on this load
      read_configuration_word <= addr_i & ~fotp_pkg::CFG_RESERVED_MASK;
    end
  end

  // ==========================================
  // otp program engine
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prog_busy <= 1'b0;
      prog_cnt <= '0;
      prog_idx <= '0;
      prog_data <= 16'h_0000;
    end else if (prog_busy) begin
      if (prog_cnt == '0) begin
        prog_busy <= 1'b0;
      end else begin
        prog_cnt <= prog_cnt - 1'b1;
      end
    end else if (prog_start) begin
      prog_busy <= 1'b1;
      prog_cnt <= ($clog2(fotp_pkg::PROG_CYCLES+1))'(fotp_pkg::PROG_CYCLES - 1);
      prog_idx <= 2'(addr_i[7:0] - fotp_pkg::ID_OTP_USER_FIRST);
      prog_data <= data_i;
    end
  end

  // otp bits only go from one to zero
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < fotp_pkg::OTP_WORDS/2; i++) begin
        otp_user[i] <= 16'h_ffff;
      end
    end else if (prog_busy && prog_cnt == '0) begin
      otp_user[prog_idx] <= otp_user[prog_idx] & prog_data;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // unique segment lock cleared at factory
      otp_lock_bits <= fotp_pkg::OTP_LOCK_RESET;
    end else if (wr_i && mode == FOTP_OTP_WAIT && !supply_low_i && part_i == PARAM_PART
                 && addr_i[7:0] == fotp_pkg::ID_OTP_LOCK && !prog_busy) begin
      // only FFFDh pattern freezes user half
      if (data_i == fotp_pkg::OTP_LOCK_USER_VALUE) begin
        otp_lock_bits[fotp_pkg::LOCK_USER_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================
  // status flags, error bits sticky until clear command, ready bit recomputed every cycle
  logic err_supply;
  logic err_range;
  logic err_locked;
  logic err_seq;
  always_comb begin
    err_supply = 1'b0;
    err_range = 1'b0;
    err_locked = 1'b0;
    err_seq = 1'b0;
    if (wr_i && mode == FOTP_OTP_WAIT) begin
      if (supply_low_i) begin
        err_supply = 1'b1;
      end else if (!is_otp_addr(addr_i) || part_i != PARAM_PART
                   || (addr_i[7:0] >= fotp_pkg::ID_OTP_FIRST
                       && addr_i[7:0] < fotp_pkg::ID_OTP_USER_FIRST)) begin
        err_range = 1'b1;
      end else if (!otp_lock_bits[fotp_pkg::LOCK_USER_BIT] || prog_busy) begin
        err_locked = 1'b1;
      end
    end
    if (wr_cmd && supply_low_i && (cmd == fotp_pkg::CMD_WORD_PROGRAM
                                   || cmd == fotp_pkg::CMD_BLOCK_ERASE)) begin
      err_supply = 1'b1;
    end
    if (wr_i && mode == FOTP_CFG_WAIT && cmd != fotp_pkg::CMD_CFG_CONFIRM) begin
      err_seq = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_flags <= fotp_pkg::SF_RESET;
    end else begin
      // set wins over a clear in the same cycle
      if (wr_cmd && cmd == fotp_pkg::CMD_CLEAR_STATUS) begin
        status_flags[fotp_pkg::SF_CMD_ERR] <= 1'b0;
        status_flags[fotp_pkg::SF_PROG_ERR] <= 1'b0;
        status_flags[fotp_pkg::SF_SUPPLY_ERR] <= 1'b0;
      end
      if (err_supply) begin
        status_flags[fotp_pkg::SF_SUPPLY_ERR] <= 1'b1;
      end
      if (err_range || err_locked) begin
        status_flags[fotp_pkg::SF_PROG_ERR] <= 1'b1;
      end
      if (err_locked || err_seq) begin
        status_flags[fotp_pkg::SF_CMD_ERR] <= 1'b1;
        status_flags[fotp_pkg::SF_PROG_ERR] <= 1'b1;
      end
      // start counted too, else ready blinks high as programming begins
      status_flags[fotp_pkg::SF_READY] <= !(prog_busy || prog_start
                                            || (next_mode == FOTP_OTP_WAIT));
    end
  end

  // ==========================================
  // read data path
  logic [15:0] id_word;
  logic [7:0] id_off;
  always_comb begin
    id_off = addr_i[7:0];
    id_word = 16'h_0000;
    if (id_off == fotp_pkg::ID_CFG_WORD) begin
      id_word = read_configuration_word;
    end else if (id_off == fotp_pkg::ID_OTP_LOCK) begin
      id_word = otp_lock_bits;
    end else if (id_off >= fotp_pkg::ID_OTP_FIRST && id_off < fotp_pkg::ID_OTP_USER_FIRST) begin
      id_word = UNIQUE_ID[16*(id_off - fotp_pkg::ID_OTP_FIRST) +: 16];
    end else if (id_off >= fotp_pkg::ID_OTP_USER_FIRST && id_off <= fotp_pkg::ID_OTP_LAST) begin
      id_word = otp_user[2'(id_off - fotp_pkg::ID_OTP_USER_FIRST)];
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 16'h_0000;
      rvalid_o <= 1'b0;
      conflict_o <= 1'b0;
    end else begin
      rvalid_o <= 1'b0;
      conflict_o <= 1'b0;
      if (rd_i && mode == FOTP_ID) begin
        // otp reads are refused with conflict while shared use is busy
        // sixteen bits per read in any partition
        if (is_otp_addr(addr_i) && (otp_blocked
            || (main_busy_i && main_busy_part_i == part_i))) begin
          conflict_o <= 1'b1;
          rdata_o <= {8'h_00, status_flags};
        end else begin
          rdata_o <= id_word;
        end
        rvalid_o <= 1'b1;
      end else if (rd_i && (mode == FOTP_STATUS || prog_busy) && part_i == PARAM_PART) begin
        rdata_o <= {8'h_00, status_flags};
        rvalid_o <= 1'b1;
      end else if (rd_i && mode == FOTP_STATUS) begin
        rdata_o <= {8'h_00, status_flags};
        rvalid_o <= 1'b1;
      end
    end
  end

  // ==========================================
  // decoded configuration outputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      read_configuration_word_o <= fotp_pkg::CFG_RESET;
      read_mode_select_o <= 1'b1;
      first_access_latency_o <= fotp_pkg::CFG_RESET[fotp_pkg::CFG_LAT_HI:fotp_pkg::CFG_LAT_LO];
      stall_polarity_o <= 1'b1;
      output_hold_length_o <= 1'b1;
      stall_timing_o <= 1'b1;
      burst_order_o <= 1'b1;
      clock_edge_select_o <= 1'b1;
      burst_wrap_disable_o <= 1'b1;
      burst_words_o <= fotp_pkg::BURST_NONE;
      single_read_only_o <= 1'b0;
      status_flags_o <= fotp_pkg::SF_RESET;
    end else begin
      read_configuration_word_o <= read_configuration_word;
      status_flags_o <= status_flags;
      read_mode_select_o <= read_configuration_word[fotp_pkg::CFG_MODE];
      first_access_latency_o <=
        read_configuration_word[fotp_pkg::CFG_LAT_HI:fotp_pkg::CFG_LAT_LO];
      stall_polarity_o <= read_configuration_word[fotp_pkg::CFG_POL];
      output_hold_length_o <= read_configuration_word[fotp_pkg::CFG_HOLD];
      stall_timing_o <= read_configuration_word[fotp_pkg::CFG_STALL];
      burst_order_o <= read_configuration_word[fotp_pkg::CFG_ORDER];
      clock_edge_select_o <= read_configuration_word[fotp_pkg::CFG_EDGE];
      burst_wrap_disable_o <= read_configuration_word[fotp_pkg::CFG_NOWRAP];
      // async page fixed at four words
      if (read_configuration_word[fotp_pkg::CFG_MODE]) begin
        burst_words_o <= fotp_pkg::BURST_4;
      end else begin
        burst_words_o <=
          burst_len(read_configuration_word[fotp_pkg::CFG_LEN_HI:fotp_pkg::CFG_LEN_LO]);
      end
      single_read_only_o <= (next_mode != FOTP_ARRAY);
    end
  end

endmodule
`default_nettype wire

// >>> core/fotp_pkg.sv
`default_nettype none
package fotp_pkg;
  // ==========================================
  // command codes on the data bus
  localparam logic [7:0] CMD_READ_ARRAY = 8'h_ff;
  localparam logic [7:0] CMD_READ_ID = 8'h_90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h_70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h_50;
  localparam logic [7:0] CMD_CFG_SETUP = 8'h_60;
  localparam logic [7:0] CMD_CFG_CONFIRM = 8'h_03;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'h_c0;
  localparam logic [7:0] CMD_WORD_PROGRAM = 8'h_40;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h_20;

  // ==========================================
  // identifier space word offsets
  localparam logic [7:0] ID_CFG_WORD = 8'h_05;
  localparam logic [7:0] ID_OTP_LOCK = 8'h_80;
  localparam logic [7:0] ID_OTP_FIRST = 8'h_81;
  localparam logic [7:0] ID_OTP_LAST = 8'h_88;
  localparam logic [7:0] ID_OTP_USER_FIRST = 8'h_85;
  localparam int OTP_WORDS = 8;
  localparam int OTP_USER_BASE = 4;

  // ==========================================
  // lock word values
  localparam logic [15:0] OTP_LOCK_RESET = 16'h_fffe;
  localparam logic [15:0] OTP_LOCK_USER_VALUE = 16'h_fffd;
  localparam int LOCK_UNIQUE_BIT = 0;
  localparam int LOCK_USER_BIT = 1;

  // ==========================================
  // status flag positions
  localparam int SF_READY = 7;
  localparam int SF_CMD_ERR = 5;
  localparam int SF_PROG_ERR = 4;
  localparam int SF_SUPPLY_ERR = 3;
  localparam logic [7:0] SF_RESET = 8'h_80;

  // ==========================================
  // read configuration word fields
  localparam logic [15:0] CFG_RESET = 16'h_bfcf;
  localparam logic [15:0] CFG_RESERVED_MASK = 16'h_4030;
  localparam int CFG_MODE = 15;
  localparam int CFG_LAT_HI = 13;
  localparam int CFG_LAT_LO = 11;
  localparam int CFG_POL = 10;
  localparam int CFG_HOLD = 9;
  localparam int CFG_STALL = 8;
  localparam int CFG_ORDER = 7;
  localparam int CFG_EDGE = 6;
  localparam int CFG_NOWRAP = 3;
  localparam int CFG_LEN_HI = 2;
  localparam int CFG_LEN_LO = 0;
  localparam logic [2:0] LAT_CODE2 = 3'h_2;
  localparam logic [2:0] LAT_CODE5 = 3'h_5;
  localparam logic [2:0] LEN_4 = 3'h_1;
  localparam logic [2:0] LEN_8 = 3'h_2;
  localparam logic [2:0] LEN_16 = 3'h_3;
  localparam logic [2:0] LEN_CONT = 3'h_7;
  localparam logic [4:0] BURST_4 = 5'h_04;
  localparam logic [4:0] BURST_8 = 5'h_08;
  localparam logic [4:0] BURST_16 = 5'h_10;
  localparam logic [4:0] BURST_NONE = 5'h_00;

  // ==========================================
  // program time of one word, in cycles
  localparam int PROG_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// >>> testbench/flash_otp_and_read_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module flash_otp_and_read_config_tb;
  logic sys_clk_i;
  logic sys_rst_i;
  logic supply_low;
  logic main_busy;
  logic [1:0] busy_part;
  logic param_busy;
  logic wr;
  logic rd;
  logic [1:0] part;
  logic [15:0] addr;
  logic [15:0] data;
  logic [15:0] rdata;
  logic rvalid;
  logic conflict;
  logic [7:0] st;
  logic [15:0] cfg;
  logic rm;
  logic [2:0] lat;
  logic pol;
  logic hold;
  logic stall;
  logic order;
  logic cedge;
  logic nowrap;
  logic [4:0] bw;
  logic sro;
  int fail_count = 0;
  int check_count = 0;
  logic [15:0] cfg_val [5] = '{16'h_1c81, 16'h_2102, 16'h_5acb, 16'h_1487, 16'h_a8a2};
  logic [4:0] cfg_len [5] = '{fotp_pkg::BURST_4, fotp_pkg::BURST_8, fotp_pkg::BURST_16,
    fotp_pkg::BURST_NONE, fotp_pkg::BURST_4};
  logic [1:0] rp [4] = '{2'h_0, 2'h_1, 2'h_0, 2'h_0};
  logic [15:0] ra [4] = '{16'h_0081, 16'h_0086, 16'h_0086, 16'h_0089};
  logic [2:0] rs [4] = '{3'h_2, 3'h_2, 3'h_1, 3'h_2};
  fotp_core u_fotp_core (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wr_i(wr), .rd_i(rd),
    .part_i(part), .addr_i(addr), .data_i(data), .supply_low_i(supply_low),
    .main_busy_i(main_busy), .main_busy_part_i(busy_part), .param_busy_i(param_busy),
    .rdata_o(rdata), .rvalid_o(rvalid), .conflict_o(conflict), .status_flags_o(st),
    .read_configuration_word_o(cfg), .read_mode_select_o(rm), .first_access_latency_o(lat),
    .stall_polarity_o(pol), .output_hold_length_o(hold), .stall_timing_o(stall),
    .burst_order_o(order), .clock_edge_select_o(cedge), .burst_wrap_disable_o(nowrap),
    .burst_words_o(bw), .single_read_only_o(sro));
  fotp_host u_fotp_host (.sys_clk_i(sys_clk_i), .rvalid_i(rvalid), .conflict_i(conflict),
    .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .part_o(part), .addr_o(addr), .data_o(data));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] p, input logic [15:0] a, input logic [7:0] c);
    u_fotp_host.wr(p, a, {8'h_00, c});
  endtask
  task automatic rdx(input logic [1:0] p, input logic [15:0] a, output logic [17:0] r);
    logic [15:0] q;
    logic c;
    logic v;
    u_fotp_host.rd(p, a, q, c, v);
    r = {v, c, q};
  endtask
  task automatic prog(input logic [1:0] p, input logic [15:0] a, input logic [15:0] d);
    int n;
    cmd(2'h_0, 16'h_0000, fotp_pkg::CMD_OTP_PROGRAM);
    u_fotp_host.wr(p, a, d);
    repeat (2) @(negedge sys_clk_i);
    n = 0;
    while (st[fotp_pkg::SF_READY] !== 1'b1 && n < 40) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // whole run needs about 200 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    test_done();
  end
  // ==========================================
  // tests
  initial begin
    logic [15:0] e;
    logic [17:0] r;
    supply_low = 1'b0;
    main_busy = 1'b0;
    busy_part = 2'h_0;
    param_busy = 1'b0;
    sys_rst_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(18'(cfg), 18'(fotp_pkg::CFG_RESET));
    chk(18'(bw), 18'(fotp_pkg::BURST_4));
    chk(18'(st), 18'(fotp_pkg::SF_RESET));
    $display("test reset done");
    // no table entry is sync, latency 2, long hold and early stall
    for (int i = 0; i < 5; i++) begin
      e = cfg_val[i] & ~fotp_pkg::CFG_RESERVED_MASK;
      supply_low = i[0];
      cmd(2'h_1, cfg_val[i], fotp_pkg::CMD_CFG_SETUP);
      cmd(2'h_1, cfg_val[i], fotp_pkg::CMD_CFG_CONFIRM);
      repeat (2) @(negedge sys_clk_i);
      supply_low = 1'b0;
      chk(18'(cfg), 18'(e));
      chk(18'({rm, lat, pol, hold, stall, order, cedge, nowrap}), 18'({e[15], e[13:6], e[3]}));
      chk(18'(bw), 18'(cfg_len[i]));
      rdx(2'h_1, 16'h_0005, r);
      chk(18'({r[17], sro}), 18'h_0);
      cmd(2'h_1, 16'h_0000, fotp_pkg::CMD_READ_ID);
      rdx(2'h_1, 16'h_0005, r);
      chk(r, {2'b10, e});
      chk(18'(sro), 18'h_1);
      cmd(2'h_1, 16'h_0000, fotp_pkg::CMD_READ_ARRAY);
    end
    $display("test config done");
    cmd(2'h_1, 16'h_1c81, fotp_pkg::CMD_CFG_SETUP);
    cmd(2'h_1, 16'h_1c81, fotp_pkg::CMD_WORD_PROGRAM);
    repeat (2) @(negedge sys_clk_i);
    chk(18'(st[5:3]), 18'h_6);
    chk(18'(cfg), 18'h_a882);
    cmd(2'h_0, 16'h_0000, fotp_pkg::CMD_CLEAR_STATUS);
    repeat (2) @(negedge sys_clk_i);
    chk(18'(st[5:3]), 18'h_0);
    supply_low = 1'b1;
    cmd(2'h_1, 16'h_0000, fotp_pkg::CMD_BLOCK_ERASE);
    supply_low = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(18'(st[5:3]), 18'h_1);
    cmd(2'h_1, 16'h_0000, fotp_pkg::CMD_READ_STATUS);
    rdx(2'h_1, 16'h_0000, r);
    chk(r, {2'b10, 16'h_0088});
    cmd(2'h_0, 16'h_0000, fotp_pkg::CMD_CLEAR_STATUS);
    $display("test bad confirm done");
    prog(2'h_0, 16'h_0085, 16'h_1234);
    cmd(2'h_0, 16'h_0000, fotp_pkg::CMD_READ_ID);
    rdx(2'h_0, 16'h_0085, r);
    chk(r, {2'b10, 16'h_1234});
    for (int i = 0; i < 4; i++) begin
      supply_low = (i == 2);
      prog(rp[i], ra[i], 16'h_0000);
      supply_low = 1'b0;
      chk(18'(st[5:3]), 18'(rs[i]));
      cmd(2'h_0, 16'h_0000, fotp_pkg::CMD_CLEAR_STATUS);
    end
    prog(2'h_0, 16'h_0080, fotp_pkg::OTP_LOCK_USER_VALUE);
    prog(2'h_0, 16'h_0086, 16'h_0000);
    chk(18'(st[5:3]), 18'h_6);
    cmd(2'h_0, 16'h_0000, fotp_pkg::CMD_CLEAR_STATUS);
    cmd(2'h_0, 16'h_0000, fotp_pkg::CMD_READ_ID);
    rdx(2'h_0, 16'h_0080, r);
    chk(r, {2'b10, 16'h_fffc});
    rdx(2'h_0, 16'h_0086, r);
    chk(r, {2'b10, 16'h_ffff});
    $display("test otp done");
    cmd(2'h_1, 16'h_0000, fotp_pkg::CMD_READ_ID);
    cmd(2'h_2, 16'h_0000, fotp_pkg::CMD_READ_ID);
    param_busy = 1'b1;
    rdx(2'h_1, 16'h_0085, r);
    chk(18'(r[17:16]), 18'h_3);
    param_busy = 1'b0;
    main_busy = 1'b1;
    busy_part = 2'h_1;
    rdx(2'h_2, 16'h_0085, r);
    chk(r, {2'b10, 16'h_1234});
    main_busy = 1'b0;
    $display("test shared access done");
    test_done();
  end
endmodule
`default_nettype wire

// >>> testbench/fotp_core_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module fotp_core_monitor (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic supply_low_i,
  input wire logic rvalid_o,
  input wire logic conflict_o,
  input wire logic [7:0] status_flags_o,
  input wire logic [15:0] read_configuration_word_o,
  input wire logic read_mode_select_o,
  input wire logic [2:0] first_access_latency_o,
  input wire logic stall_polarity_o,
  input wire logic output_hold_length_o,
  input wire logic stall_timing_o,
  input wire logic burst_order_o,
  input wire logic clock_edge_select_o,
  input wire logic burst_wrap_disable_o,
  input wire logic [4:0] burst_words_o,
  input wire logic single_read_only_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================
  // command sequence tracking
  logic setup_seen;
  logic prog_seen;
  logic armed;
  logic [15:0] exp_cfg;
  logic cfm_ok;
  logic cfm_bad;
  logic prog_data;
  assign cfm_ok = wr_i && setup_seen && data_i[7:0] == fotp_pkg::CMD_CFG_CONFIRM;
  assign cfm_bad = wr_i && setup_seen && data_i[7:0] != fotp_pkg::CMD_CFG_CONFIRM;
  assign prog_data = wr_i && prog_seen;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      setup_seen <= 1'b0;
      prog_seen <= 1'b0;
    end else if (wr_i) begin
      setup_seen <= !setup_seen && data_i[7:0] == fotp_pkg::CMD_CFG_SETUP;
      prog_seen <= !prog_seen && data_i[7:0] == fotp_pkg::CMD_OTP_PROGRAM;
    end
  end
  // burst count lags reset by one edge
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      exp_cfg <= fotp_pkg::CFG_RESET;
    end else if (cfm_ok) begin
      exp_cfg <= addr_i & ~fotp_pkg::CFG_RESERVED_MASK;
    end
  end
  // ==========================================
  // checks
  a_rvalid_cause: assert property (rvalid_o |-> $past(rd_i))
    else $error("read answer without a read");
  a_read_mode: assert property (rd_i |=> rvalid_o == $past(single_read_only_o))
    else $error("read answer does not follow read mode");
  a_conflict_valid: assert property (conflict_o |-> rvalid_o)
    else $error("refusal flag outside a read answer");
  a_cfg_load: assert property (cfm_ok |-> ##[1:3] read_configuration_word_o == exp_cfg)
    else $error("config word not loaded");
  a_bad_cfm_hold: assert property (cfm_bad |=> $stable(read_configuration_word_o)[*3])
    else $error("config word changed on bad confirm");
  a_bad_cfm_flags: assert property (cfm_bad |-> ##[1:2] status_flags_o[5:4] == 2'b11)
    else $error("bad confirm not flagged");
  a_supply_flag: assert property (prog_data && supply_low_i |-> ##[1:2] status_flags_o[3])
    else $error("low supply not flagged");
  a_range_flag: assert property (prog_data && !supply_low_i && (addr_i > 16'h_0088 ||
    (addr_i < 16'h_0085 && addr_i != 16'h_0080)) |-> ##[1:2] status_flags_o[4])
    else $error("out of range program not flagged");
  a_cfg_decode: assert property ({read_mode_select_o, first_access_latency_o, stall_polarity_o,
    output_hold_length_o, stall_timing_o, burst_order_o, clock_edge_select_o,
    burst_wrap_disable_o} == {read_configuration_word_o[15], read_configuration_word_o[13:6],
    read_configuration_word_o[3]})
    else $error("config decode mismatch");
  a_async_burst: assert property (armed && read_configuration_word_o[15] |->
    burst_words_o == fotp_pkg::BURST_4)
    else $error("async mode burst count not four");
endmodule
bind fotp_core fotp_core_monitor u_fotp_core_monitor (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .data_i(data_i),
  .supply_low_i(supply_low_i), .rvalid_o(rvalid_o), .conflict_o(conflict_o),
  .status_flags_o(status_flags_o), .read_configuration_word_o(read_configuration_word_o),
  .read_mode_select_o(read_mode_select_o), .first_access_latency_o(first_access_latency_o),
  .stall_polarity_o(stall_polarity_o), .output_hold_length_o(output_hold_length_o),
  .stall_timing_o(stall_timing_o), .burst_order_o(burst_order_o),
  .clock_edge_select_o(clock_edge_select_o), .burst_wrap_disable_o(burst_wrap_disable_o),
  .burst_words_o(burst_words_o), .single_read_only_o(single_read_only_o));
`default_nettype wire

// >>> testbench/fotp_host.sv
`timescale 1ns/10ps
`default_nettype none
module fotp_host (
  input wire logic sys_clk_i,
  input wire logic rvalid_i,
  input wire logic conflict_i,
  input wire logic [15:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [1:0] part_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    part_o = 2'h_0;
    addr_o = 16'h_0000;
    data_o = 16'h_0000;
  end
  // ==========================================
  // bus cycles
  // value held for one write
  task automatic wr(input logic [1:0] p, input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    wr_o = 1'b1;
    part_o = p;
    addr_o = a;
    data_o = d;
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    // released address and data lines never keep the old value
    addr_o = ~a;
    data_o = ~d;
  endtask
  task automatic rd(input logic [1:0] p, input logic [15:0] a, output logic [15:0] q,
    output logic c, output logic v);
    @(negedge sys_clk_i);
    rd_o = 1'b1;
    part_o = p;
    addr_o = a;
    @(negedge sys_clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    v = rvalid_i;
    c = conflict_i;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire
